// file: core/vibration_map.vh
`ifndef VIBRATION_MAP_VH
`define VIBRATION_MAP_VH

// Register byte offsets
`define REG_CONFIG 8'h00
`define REG_SPAN 8'h04
`define REG_LOWEST 8'h08
`define REG_BIN_WIDTH 8'h0C
`define REG_SENSITIVITY 8'h10
`define REG_AVERAGING 8'h14
`define REG_STATUS 8'h18
`define REG_BAND_BASE 4'h2
`define BAND_START 2'h0
`define BAND_STOP 2'h1
`define BAND_MODE 2'h2
`define BAND_RESULT 2'h3
`define TEXT_BASE 12'h100
`define TEXT_FIELDS 5
`define TEXT_WORDS 6

// Field positions
`define CFG_VELOCITY 0
`define CFG_POWER_EN 1
`define MODE_INTEGRATE 0
`define STATUS_CFG_ERROR 0

// Reset values
`define SPAN_RESET 15'h1388
`define SENS_RESET 17'h003E8
`define AVG_RESET 4'h6
`define START_RESET 25'h0001388
`define STOP_RESET 25'h04C4B40
`define CONFIG_RESET 32'h00000002
`define MODE_RESET 3'h0

// Limits (span in Hz, sensitivity in 0.1 mV units)
`define SPAN_MIN 15'h00C8
`define SPAN_MAX 15'h4E20
`define SENS_MIN 17'h0005A
`define SENS_MAX 17'h1ADB0
`define SPAN_TO_MHZ 10'h3E8

// Detector choices
`define DET_RMS 2'h0
`define DET_PEAK 2'h1
`define DET_P2P 2'h2

// Timing: sample rate is 5/2 of the span, block length 256 samples
`define CLK_HZ 26'h1312D00
`define SAMPLE_MUL 3'h5
`define BLOCK_LOG2 8
`define SQRT2_Q15 16'hB505

`endif

// file: core/band_channel.v
`timescale 1ns/10ps
`include "vibration_map.vh"

module band_channel (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Settings
  input wire [14:0] span_hz,
  input wire [24:0] start_mhz,
  input wire [24:0] stop_mhz,
  input wire integrate,
  input wire [1:0] detector,
  input wire [3:0] avg_shift,
  // Samples
  input wire signed [15:0] sample,
  input wire sample_valid,
  input wire block_end,
  // Result
  output reg [17:0] result,
  output reg result_valid
);

  // Smallest shift k with 2^-k at or below 2*pi*fc/fs, fs = 2.5 * span
  function [3:0] corner_shift;
    input [24:0] fc;
    input [14:0] span;
    reg [47:0] lhs;
    reg [47:0] rhs;
    integer k;
    begin
      corner_shift = 4'hF;
      rhs = span * 48'd2000;
      for (k = 15; k >= 1; k = k - 1) begin
        lhs = (fc * 48'd5) << k;
        if (lhs >= rhs)
          corner_shift = k[3:0];
      end
    end
  endfunction

  wire [3:0] hp_shift = corner_shift(start_mhz, span_hz);
  wire [3:0] lp_shift = corner_shift(stop_mhz, span_hz);

  reg signed [23:0] lp;
  reg signed [23:0] hp;
  reg signed [31:0] integ;
  reg [39:0] pow_acc;
  reg [31:0] avg;
  reg sqrt_busy;
  reg [4:0] sqrt_cnt;
  reg [31:0] rad;
  reg [17:0] rem;
  reg [15:0] root;

  wire signed [23:0] x = {sample, 8'h00};
  wire signed [23:0] next_lp = lp + ((x - lp) >>> lp_shift);
  wire signed [23:0] next_hp = hp + ((next_lp - hp) >>> hp_shift);
  wire signed [23:0] band = next_lp - next_hp;
  wire signed [31:0] next_integ = integ + band - (integ >>> hp_shift);
  // Output quantity: integrated or as sensed
  wire signed [15:0] v = integrate ? next_integ[27:12] : band[23:8];
  wire [31:0] sq = v * v;
  wire [39:0] pow_sum = pow_acc + {8'h00, sq};
  wire [31:0] blk = pow_sum[39:`BLOCK_LOG2];
  wire signed [32:0] diff = {1'b0, blk} - {1'b0, avg};
  wire signed [32:0] step = diff >>> avg_shift;
  // Two guard bits: the partial remainder can reach twice the root
  wire [19:0] rem_n = {rem, rad[31:30]};
  wire [19:0] trial = {2'b00, root, 2'b01};
  wire [19:0] rem_diff = rem_n - trial;
  wire [31:0] peak_full = root * `SQRT2_Q15;
  wire [16:0] peak = peak_full[31:15];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lp <= 24'h000000;
      hp <= 24'h000000;
      integ <= 32'h00000000;
      pow_acc <= 40'h0000000000;
      avg <= 32'h00000000;
    end else if (sample_valid) begin
      lp <= next_lp;
      hp <= next_hp;
      integ <= next_integ;
      if (block_end) begin
        pow_acc <= 40'h0000000000;
        // First-order smoothing: ~4 time constants to reach 98 percent
        avg <= avg + step[31:0];
      end else begin
        pow_acc <= pow_sum;
      end
    end
  end

  // Bit-serial square root of the averaged power gives true RMS first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sqrt_busy <= 1'b0;
      sqrt_cnt <= 5'h00;
      rad <= 32'h00000000;
      rem <= 18'h00000;
      root <= 16'h0000;
      result <= 18'h00000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (sample_valid && block_end && !sqrt_busy) begin
        sqrt_busy <= 1'b1;
        sqrt_cnt <= 5'h10;
        rad <= avg + step[31:0];
        rem <= 18'h00000;
        root <= 16'h0000;
      end else if (sqrt_busy && sqrt_cnt != 5'h00) begin
        sqrt_cnt <= sqrt_cnt - 5'h01;
        rad <= {rad[29:0], 2'b00};
        if (rem_n >= trial) begin
          rem <= rem_diff[17:0];
          root <= {root[14:0], 1'b1};
        end else begin
          rem <= rem_n[17:0];
          root <= {root[14:0], 1'b0};
        end
      end else if (sqrt_busy) begin
        sqrt_busy <= 1'b0;
        result_valid <= 1'b1;
        case (detector)
          `DET_PEAK: result <= {1'b0, peak};
          `DET_P2P: result <= {peak, 1'b0};
          default: result <= {2'b00, root};
        endcase
      end
    end
  end

endmodule // band_channel

// file: core/vibration_band_detector.v
`timescale 1ns/10ps
`include "vibration_map.vh"

module vibration_band_detector (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Converter samples
  output reg sample_request,
  input wire signed [15:0] sample_data,
  input wire sample_valid,
  // Sensor front end
  output wire sensor_power_en,
  output wire sensor_is_velocity,
  // Results
  output wire [17:0] band0_result,
  output wire band0_valid,
  output wire [17:0] band1_result,
  output wire band1_valid
);

  reg [31:0] config_reg;
  reg [14:0] span;
  reg [16:0] sensitivity;
  reg [3:0] avg_shift;
  reg cfg_error;
  reg [24:0] fstart0;
  reg [24:0] fstart1;
  reg [24:0] fstop0;
  reg [24:0] fstop1;
  reg [2:0] mode0;
  reg [2:0] mode1;
  reg [31:0] text_mem [0:`TEXT_FIELDS*`TEXT_WORDS-1];
  reg [11:0] addr_q;
  reg wr_q;
  reg [26:0] phase;
  reg [7:0] sample_cnt;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sensor_power_en = config_reg[`CFG_POWER_EN];
  assign sensor_is_velocity = config_reg[`CFG_VELOCITY];

  wire take = hsel && hready && htrans[1];
  wire [24:0] span_mhz = span * `SPAN_TO_MHZ;
  // Lowest frequency in mHz equals the span in Hz, i.e. span / 1000
  wire [24:0] lowest_mhz = {10'h000, span};
  wire [24:0] bin_mhz = (span * 25'd2500) >> `BLOCK_LOG2;

  // Address decode of the latched data-phase address
  wire is_band = (addr_q[11:5] == 7'h01);
  wire bsel = addr_q[4];
  wire [1:0] bfield = addr_q[3:2];
  wire [11:0] text_off = addr_q - `TEXT_BASE;
  wire [2:0] text_field = text_off[7:5];
  wire [2:0] text_word = text_off[4:2];
  wire is_text = (addr_q[11:8] == 4'h1) && (text_field < `TEXT_FIELDS)
    && (text_word < `TEXT_WORDS);
  wire [4:0] text_idx = text_field * 3'd6 + {2'b00, text_word};

  // Settings of the addressed band
  wire [24:0] sel_start = bsel ? fstart1 : fstart0;
  wire [24:0] sel_stop = bsel ? fstop1 : fstop0;
  wire [2:0] sel_mode = bsel ? mode1 : mode0;

  // Write checks
  wire [14:0] new_span = hwdata[14:0];
  wire [24:0] new_span_mhz = new_span * `SPAN_TO_MHZ;
  wire span_ok = (hwdata[31:15] == 17'h00000) && (new_span >= `SPAN_MIN)
    && (new_span <= `SPAN_MAX)
    && (fstart0 >= {10'h000, new_span}) && (fstart1 >= {10'h000, new_span})
    && (fstop0 <= new_span_mhz) && (fstop1 <= new_span_mhz);
  wire [24:0] new_f = hwdata[24:0];
  wire f_in_range = (hwdata[31:25] == 7'h00) && (new_f >= lowest_mhz)
    && (new_f <= span_mhz);
  wire start_ok = f_in_range && (new_f < sel_stop);
  wire stop_ok = f_in_range && (new_f > sel_start);
  wire sens_ok = (hwdata[31:17] == 15'h0000) && (hwdata[16:0] >= `SENS_MIN)
    && (hwdata[16:0] <= `SENS_MAX);
  wire mode_ok = (hwdata[2:1] != 2'h3);

  // Write strobes from the latched data-phase address
  wire sys_page = (addr_q[11:8] == 4'h0) && !is_band;
  wire wr_config = wr_q && sys_page && (addr_q[7:0] == `REG_CONFIG);
  wire wr_span = wr_q && sys_page && (addr_q[7:0] == `REG_SPAN);
  wire wr_sens = wr_q && sys_page && (addr_q[7:0] == `REG_SENSITIVITY);
  wire wr_avg = wr_q && sys_page && (addr_q[7:0] == `REG_AVERAGING);
  wire wr_status = wr_q && sys_page && (addr_q[7:0] == `REG_STATUS);
  wire band_wr = wr_q && is_band;
  wire wr_start0 = band_wr && !bsel && (bfield == `BAND_START);
  wire wr_start1 = band_wr && bsel && (bfield == `BAND_START);
  wire wr_stop0 = band_wr && !bsel && (bfield == `BAND_STOP);
  wire wr_stop1 = band_wr && bsel && (bfield == `BAND_STOP);
  wire wr_mode0 = band_wr && !bsel && (bfield == `BAND_MODE);
  wire wr_mode1 = band_wr && bsel && (bfield == `BAND_MODE);

  reg bad_write;
  always @* begin
    bad_write = 1'b0;
    if (wr_q) begin
      if (addr_q[7:0] == `REG_SPAN && addr_q[11:8] == 4'h0)
        bad_write = !span_ok;
      else if (addr_q[7:0] == `REG_SENSITIVITY && addr_q[11:8] == 4'h0)
        bad_write = !sens_ok;
      else if (is_band && bfield == `BAND_START)
        bad_write = !start_ok;
      else if (is_band && bfield == `BAND_STOP)
        bad_write = !stop_ok;
      else if (is_band && bfield == `BAND_MODE)
        bad_write = !mode_ok;
    end
  end

  // Bus phase capture
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 12'h000;
      wr_q <= 1'b0;
    end else if (hready) begin
      addr_q <= {haddr[11:2], 2'b00};
      wr_q <= take && hwrite;
    end
  end

  // Control registers; a rejected write leaves the old value in place
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= `CONFIG_RESET;
    end else if (wr_config) begin
      config_reg <= {30'h00000000, hwdata[1:0]};
    end
  end

  // The span check also covers both bands, so no cutoff is left outside
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      span <= `SPAN_RESET;
    end else if (wr_span && span_ok) begin
      span <= new_span;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sensitivity <= `SENS_RESET;
    end else if (wr_sens && sens_ok) begin
      sensitivity <= hwdata[16:0];
    end
  end

  // Any shift is legal; a larger one trades settling time for smoothness
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avg_shift <= `AVG_RESET;
    end else if (wr_avg) begin
      avg_shift <= hwdata[3:0];
    end
  end

  // Error flag: a new fault wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_error <= 1'b0;
    end else if (bad_write) begin
      cfg_error <= 1'b1;
    end else if (wr_status && hwdata[`STATUS_CFG_ERROR]) begin
      cfg_error <= 1'b0;
    end
  end

  // Band 0 cutoffs and output mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstart0 <= `START_RESET;
    end else if (wr_start0 && start_ok) begin
      fstart0 <= new_f;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstop0 <= `STOP_RESET;
    end else if (wr_stop0 && stop_ok) begin
      fstop0 <= new_f;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode0 <= `MODE_RESET;
    end else if (wr_mode0 && mode_ok) begin
      mode0 <= hwdata[2:0];
    end
  end

  // Band 1 cutoffs and output mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstart1 <= `START_RESET;
    end else if (wr_start1 && start_ok) begin
      fstart1 <= new_f;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstop1 <= `STOP_RESET;
    end else if (wr_stop1 && stop_ok) begin
      fstop1 <= new_f;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode1 <= `MODE_RESET;
    end else if (wr_mode1 && mode_ok) begin
      mode1 <= hwdata[2:0];
    end
  end

  // Text fields hold no control state, so they are left out of reset
  always @(posedge clk) begin
    if (wr_q && is_text)
      text_mem[text_idx] <= hwdata;
  end

  // Read mux: one word per page, then the page select
  reg [31:0] sys_rdata;
  reg [31:0] band_rdata;
  always @* begin
    case (addr_q[7:0])
      `REG_CONFIG: sys_rdata = config_reg;
      `REG_SPAN: sys_rdata = {17'h00000, span};
      `REG_LOWEST: sys_rdata = {7'h00, lowest_mhz};
      `REG_BIN_WIDTH: sys_rdata = {7'h00, bin_mhz};
      `REG_SENSITIVITY: sys_rdata = {15'h0000, sensitivity};
      `REG_AVERAGING: sys_rdata = {28'h0000000, avg_shift};
      `REG_STATUS: sys_rdata = {31'h00000000, cfg_error};
      default: sys_rdata = 32'h00000000;
    endcase
  end

  always @* begin
    case (bfield)
      `BAND_START: band_rdata = {7'h00, sel_start};
      `BAND_STOP: band_rdata = {7'h00, sel_stop};
      `BAND_MODE: band_rdata = {29'h00000000, sel_mode};
      default: band_rdata = {14'h0000, bsel ? band1_result : band0_result};
    endcase
  end

  always @* begin
    if (is_text) begin
      hrdata = text_mem[text_idx];
    end else if (is_band) begin
      hrdata = band_rdata;
    end else if (addr_q[11:8] == 4'h0) begin
      hrdata = sys_rdata;
    end else begin
      hrdata = 32'h00000000;
    end
  end

  // Sample pacing: rate is 5/2 of the span, so a lower span slows blocks
  // Kept at 18 bits: five times the top span does not fit in 15
  wire [17:0] span_x5 = span * `SAMPLE_MUL;
  wire [27:0] phase_sum = {1'b0, phase} + {10'h000, span_x5};
  wire [27:0] wrap = {1'b0, `CLK_HZ, 1'b0};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 27'h0000000;
      sample_request <= 1'b0;
    end else if (phase_sum >= wrap) begin
      phase <= phase_sum[26:0] - wrap[26:0];
      sample_request <= 1'b1;
    end else begin
      phase <= phase_sum[26:0];
      sample_request <= 1'b0;
    end
  end

  wire block_end = (sample_cnt == 8'hFF);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      sample_cnt <= 8'h00;
    else if (sample_valid)
      sample_cnt <= sample_cnt + 8'h01;
  end

  band_channel band0 (
    .clk(clk),
    .reset_n(reset_n),
    .span_hz(span),
    .start_mhz(fstart0),
    .stop_mhz(fstop0),
    .integrate(mode0[`MODE_INTEGRATE]),
    .detector(mode0[2:1]),
    .avg_shift(avg_shift),
    .sample(sample_data),
    .sample_valid(sample_valid),
    .block_end(block_end),
    .result(band0_result),
    .result_valid(band0_valid)
  );

  band_channel band1 (
    .clk(clk),
    .reset_n(reset_n),
    .span_hz(span),
    .start_mhz(fstart1),
    .stop_mhz(fstop1),
    .integrate(mode1[`MODE_INTEGRATE]),
    .detector(mode1[2:1]),
    .avg_shift(avg_shift),
    .sample(sample_data),
    .sample_valid(sample_valid),
    .block_end(block_end),
    .result(band1_result),
    .result_valid(band1_valid)
  );

endmodule // vibration_band_detector

// file: testbench/vibration_band_detector_sva.sv
`timescale 1ns/10ps

module vibration_band_detector_sva (
  // Clock and reset
  input logic clk, reset_n,
  // Register bus
  input logic hsel, hready, hwrite, hreadyout, hresp,
  input logic [11:0] haddr,
  input logic [1:0] htrans,
  input logic [31:0] hwdata, hrdata,
  // Stream, front end and results
  input logic sample_request, sample_valid, sensor_power_en, sensor_is_velocity,
  input logic band0_valid, band1_valid,
  input logic [17:0] band0_result, band1_result
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Shadow sample count; counts every sample_valid just as the design counter does, at any spacing
  logic [7:0] blk_cnt;
  wire blk_end = sample_valid && blk_cnt == 8'hFF;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blk_cnt <= 8'h00;
    end else if (sample_valid) begin
      blk_cnt <= blk_cnt + 8'h01;
    end
  end
  sequence cfg_wr_s;
    hsel && hready && htrans[1] && hwrite && haddr == 12'h000 ##1 1'b1;
  endsequence
  sequence span_bad_s;
    hsel && hready && htrans[1] && hwrite && haddr == 12'h004
      ##1 (hwdata < 32'h000000C8 || hwdata > 32'h00004E20);
  endsequence
  sequence status_rd_s;
    hsel && hready && htrans[1] && !hwrite && haddr == 12'h018;
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  power_default_a: assert property ($rose(reset_n) |-> sensor_power_en && !sensor_is_velocity)
    else $error("front end not at default after reset");
  config_write_a: assert property (cfg_wr_s |=>
    sensor_is_velocity == $past(hwdata[0]) && sensor_power_en == $past(hwdata[1]))
    else $error("front end outputs do not follow config write");
  span_reject_a: assert property (span_bad_s ##1 status_rd_s |=> hrdata[0])
    else $error("bad span write not flagged");
  unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr == 12'h01C |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  request_pulse_a: assert property (sample_request |=> !sample_request)
    else $error("sample request longer than one cycle");
  valid_pulse_a: assert property (band0_valid |=> !band0_valid)
    else $error("band result valid longer than one cycle");
  result_hold_a: assert property ($changed(band1_result) |-> band1_valid)
    else $error("band result moved without valid");
  block_result_a: assert property (blk_end |-> ##[1:40] band0_valid)
    else $error("no band result after full block");
endmodule // vibration_band_detector_sva

bind vibration_band_detector vibration_band_detector_sva vibration_band_detector_sva_inst (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .hready(hready), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .htrans(htrans),
  .hwdata(hwdata), .hrdata(hrdata), .sample_request(sample_request),
  .sample_valid(sample_valid), .sensor_power_en(sensor_power_en),
  .sensor_is_velocity(sensor_is_velocity), .band0_valid(band0_valid),
  .band1_valid(band1_valid), .band0_result(band0_result), .band1_result(band1_result));

// file: testbench/adc_stream_model.sv
`timescale 1ns/10ps

module adc_stream_model #(
  parameter int GAP = 20,
  parameter logic [15:0] AMP = 16'h1F40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Converter output
  output logic signed [15:0] sample_data,
  output logic sample_valid
);
  int gap_cnt;
  logic [2:0] phase;
  // Square wave of eight samples; data inverts every cycle between strobes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 0;
      phase <= 3'h0;
      sample_valid <= 1'b0;
      sample_data <= 16'h0000;
    end else begin
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
      gap_cnt <= gap_cnt + 1;
      if (gap_cnt == GAP - 1) begin
        gap_cnt <= 0;
        phase <= phase + 3'h1;
        sample_valid <= 1'b1;
        sample_data <= phase[2] ? -AMP : AMP;
      end
    end
  end
endmodule // adc_stream_model

// file: testbench/vibration_band_detector_test.sv
`timescale 1ns/10ps

module vibration_band_detector_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  wire hreadyout, hresp, sample_request, sample_valid, sensor_power_en, sensor_is_velocity;
  wire band0_valid, band1_valid;
  wire [31:0] hrdata;
  wire signed [15:0] sample_data;
  wire [17:0] band0_result, band1_result;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [35:0] peak;

  vibration_band_detector vibration_band_detector_inst (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_request(sample_request), .sample_data(sample_data),
    .sample_valid(sample_valid), .sensor_power_en(sensor_power_en),
    .sensor_is_velocity(sensor_is_velocity), .band0_result(band0_result),
    .band0_valid(band0_valid), .band1_result(band1_result), .band1_valid(band1_valid));

  adc_stream_model adc_stream_model_inst (
    .clk(clk), .reset_n(reset_n), .sample_data(sample_data), .sample_valid(sample_valid));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_ready;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h00000000, rd);
    check(what, rd, exp);
  endtask

  // Status is read right after the write so the error flag is tied to that write
  task automatic try(input logic [11:0] a, input logic [31:0] v, input logic bad);
    wr(a, v);
    rchk("status", 12'h018, {31'h0, bad});
    if (bad) begin
      wr(12'h018, 32'h00000001);
    end
  endtask

  task automatic wait_block;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (band0_valid !== 1'b1 && n < 8000);
    check("band0_done", band0_valid, 1'b1);
    check("band1_done", band1_valid, 1'b1);
    repeat (4) @(posedge clk);
  endtask

  task automatic rate(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (16000) begin
      @(posedge clk);
      #1;
      if (sample_request === 1'b1) begin
        n++;
      end
    end
    @(posedge clk);
    check("request_rate", n >= exp - 1 && n <= exp + 1, 1'b1);
  endtask

  task automatic t_reset;
    rchk("config", 12'h000, 32'h00000002);
    check("power_en", sensor_power_en, 1'b1);
    check("is_velocity", sensor_is_velocity, 1'b0);
    rchk("span", 12'h004, 32'h00001388);
    rchk("lowest", 12'h008, 32'h00001388);
    rchk("bin_width", 12'h00C, 32'h0000BEBC);
    rchk("sensitivity", 12'h010, 32'h000003E8);
    rchk("averaging", 12'h014, 32'h00000006);
    rchk("stop", 12'h024, 32'h004C4B40);
    rchk("mode", 12'h038, 32'h00000000);
    wr(12'h000, 32'h00000001);
    @(posedge clk);
    check("power_off", sensor_power_en, 1'b0);
    check("velocity", sensor_is_velocity, 1'b1);
    wr(12'h000, 32'h00000002);
  endtask

  // Both bands see the same stream and settings, so only the detector scaling differs
  task automatic t_results;
    wr(12'h014, 32'h00000000);
    wr(12'h038, 32'h00000002);
    wait_block;
    wait_block;
    check("rms_nonzero", band0_result != 18'h00000, 1'b1);
    peak = (band0_result * 36'h00000B505) >> 15;
    check("equiv_peak", band1_result, peak[17:0]);
    wr(12'h038, 32'h00000004);
    wait_block;
    wait_block;
    peak = (band0_result * 36'h00000B505) >> 15;
    check("peak_to_peak", band1_result, {peak[16:0], 1'b0});
    wr(12'h038, 32'h00000000);
  endtask

  task automatic t_limits;
    try(12'h024, 32'h000186A0, 1'b0);
    try(12'h020, 32'h00004E20, 1'b0);
    try(12'h034, 32'h000186A0, 1'b0);
    try(12'h030, 32'h00004E20, 1'b0);
    try(12'h004, 32'h000000C8, 1'b0);
    rchk("lowest_min", 12'h008, 32'h000000C8);
    rchk("bin_min", 12'h00C, 32'h000007A1);
    try(12'h004, 32'h000000C7, 1'b1);
    try(12'h004, 32'h00004E21, 1'b1);
    rchk("span_kept", 12'h004, 32'h000000C8);
    try(12'h004, 32'h00004E20, 1'b0);
    rchk("lowest_max", 12'h008, 32'h00004E20);
    rate(8'h28);
    try(12'h020, 32'h000186A0, 1'b1);
    try(12'h024, 32'h00004E20, 1'b1);
    try(12'h020, 32'h00004E1F, 1'b1);
    try(12'h024, 32'h01312D01, 1'b1);
    try(12'h024, 32'h01312D00, 1'b0);
    try(12'h004, 32'h00001388, 1'b1);
    try(12'h010, 32'h00000059, 1'b1);
    try(12'h010, 32'h0000005A, 1'b0);
    try(12'h010, 32'h0001ADB1, 1'b1);
    try(12'h010, 32'h0001ADB0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      try(12'h028, i, i[2:1] == 2'h3);
    end
    rchk("mode_kept", 12'h028, 32'h00000005);
  endtask

  task automatic t_text;
    wr(12'h174, 32'h4D4F544F);
    wr(12'h194, 32'h534E3031);
    rchk("machine_text", 12'h174, 32'h4D4F544F);
    rchk("serial_text", 12'h194, 32'h534E3031);
    rchk("past_field_end", 12'h178, 32'h00000000);
    rchk("unmapped", 12'h01C, 32'h00000000);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_results;
    rate(8'h0A);
    t_limits;
    t_text;
    tally_and_finish;
  end
endmodule // vibration_band_detector_test
